// ==== xdl_map.vh ====
`ifndef XDL_MAP_VH
`define XDL_MAP_VH
// register word indices; the bus byte address is index times four
`define XDL_IDX_PORT_A_DIR   8'h12
`define XDL_IDX_PORT_B_DIR   8'h13
`define XDL_IDX_PORT_C_DIR   8'h14
`define XDL_IDX_ACCUM        8'h20
`define XDL_IDX_STATUS       8'h21
`define XDL_IDX_OPERAND      8'h22
`define XDL_IDX_COMMAND      8'h23
`define XDL_IDX_FILE_DATA    8'h24
// command codes
`define XDL_CMD_DIR_LOAD     2'h1
`define XDL_CMD_LIT_XOR      2'h2
`define XDL_CMD_FILE_XOR     2'h3
// direction selectors
`define XDL_SEL_PORT_A       8'h05
`define XDL_SEL_PORT_B       8'h06
`define XDL_SEL_PORT_C       8'h07
// field positions
`define XDL_ST_ZERO          2
`define XDL_ST_DCARRY        1
`define XDL_ST_CARRY         0
`define XDL_OP_DEST          7
// reset values
`define XDL_DIR_RESET        8'hff
`define XDL_RESET_BYTE       8'h00
`endif

// ==== xdl_exec.v ====
`timescale 1ns/1ps
`include "xdl_map.vh"
module xdl_exec (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire [9:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  output reg         file_we_out,
  output reg  [6:0]  file_addr_out,
  output reg  [7:0]  file_wdata_out,
  output reg  [7:0]  port_a_direction_out,
  output reg  [7:0]  port_b_direction_out,
  output reg  [7:0]  port_c_direction_out,
  output reg  [7:0]  accum_out,
  output reg         zero_flag_out
);

  // word index from byte address
  function [7:0] xdl_index;
    input [9:0] addr;
    begin
      xdl_index = addr[9:2];
    end
  endfunction

  // zero test of an 8-bit result, shared by both xor commands
  function xdl_is_zero;
    input [7:0] val;
    begin
      xdl_is_zero = (val == 8'h00);
    end
  endfunction

  // direction register picked by a load operand, 2'h3 when none
  function [1:0] xdl_dir_pick;
    input [7:0] op;
    begin
      if (op == `XDL_SEL_PORT_A) begin
        xdl_dir_pick = 2'h0;
      end else if (op == `XDL_SEL_PORT_B) begin
        xdl_dir_pick = 2'h1;
      end else if (op == `XDL_SEL_PORT_C) begin
        xdl_dir_pick = 2'h2;
      end else begin
        xdl_dir_pick = 2'h3;
      end
    end
  endfunction

  // read value by word index; unmapped and command read zero
  function [31:0] xdl_read_mux;
    input [7:0] sel;
    input [7:0] dir_a;
    input [7:0] dir_b;
    input [7:0] dir_c;
    input [7:0] acc;
    input [2:0] st;
    input [7:0] op;
    input [7:0] fd;
    begin
      if (sel == `XDL_IDX_PORT_A_DIR) begin
        xdl_read_mux = {24'h0, dir_a};
      end else if (sel == `XDL_IDX_PORT_B_DIR) begin
        xdl_read_mux = {24'h0, dir_b};
      end else if (sel == `XDL_IDX_PORT_C_DIR) begin
        xdl_read_mux = {24'h0, dir_c};
      end else if (sel == `XDL_IDX_ACCUM) begin
        xdl_read_mux = {24'h0, acc};
      end else if (sel == `XDL_IDX_STATUS) begin
        xdl_read_mux = {29'h0, st};
      end else if (sel == `XDL_IDX_OPERAND) begin
        xdl_read_mux = {24'h0, op};
      end else if (sel == `XDL_IDX_FILE_DATA) begin
        xdl_read_mux = {24'h0, fd};
      end else begin
        xdl_read_mux = 32'h0;
      end
    end
  endfunction

  reg  [7:0] port_a_direction_q;
  reg  [7:0] port_b_direction_q;
  reg  [7:0] port_c_direction_q;
  reg  [7:0] accum_q;
  reg  [2:0] status_q;
  reg  [7:0] operand_q;
  reg  [7:0] file_data_q;
  reg        ack_q;
  wire [7:0] idx;
  wire       wr_go;
  wire       rd_go;
  wire [7:0] lit_res;
  wire [7:0] file_res;
  wire [1:0] dir_pick;

  assign idx      = xdl_index(avs_address_in);
  assign wr_go    = avs_write_in && !ack_q && avs_byteenable_in[0];
  assign rd_go    = avs_read_in && !ack_q;
  assign lit_res  = accum_q ^ operand_q;
  assign file_res = accum_q ^ file_data_q;
  assign dir_pick = xdl_dir_pick(operand_q);

  // one wait cycle per access, answered on the next edge
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_in || avs_write_in) && !ack_q;
    end
  end

  // register writes and command execution
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_a_direction_q <= `XDL_DIR_RESET;
      port_b_direction_q <= `XDL_DIR_RESET;
      port_c_direction_q <= `XDL_DIR_RESET;
      accum_q            <= `XDL_RESET_BYTE;
      status_q           <= 3'h0;
      operand_q          <= `XDL_RESET_BYTE;
      file_data_q        <= `XDL_RESET_BYTE;
      file_we_out        <= 1'b0;
      file_addr_out      <= 7'h00;
      file_wdata_out     <= `XDL_RESET_BYTE;
    end else begin
      file_we_out <= 1'b0;
      if (wr_go) begin
        if (idx == `XDL_IDX_PORT_A_DIR) begin
          port_a_direction_q <= avs_writedata_in[7:0];
        end else if (idx == `XDL_IDX_PORT_B_DIR) begin
          port_b_direction_q <= avs_writedata_in[7:0];
        end else if (idx == `XDL_IDX_PORT_C_DIR) begin
          port_c_direction_q <= avs_writedata_in[7:0];
        end else if (idx == `XDL_IDX_ACCUM) begin
          accum_q <= avs_writedata_in[7:0];
        end else if (idx == `XDL_IDX_STATUS) begin
          status_q <= avs_writedata_in[2:0];
        end else if (idx == `XDL_IDX_OPERAND) begin
          operand_q <= avs_writedata_in[7:0];
        end else if (idx == `XDL_IDX_FILE_DATA) begin
          file_data_q <= avs_writedata_in[7:0];
        end else if (idx == `XDL_IDX_COMMAND) begin
          case (avs_writedata_in[1:0])
            `XDL_CMD_DIR_LOAD: begin
              // operand is a selector; others ignored; flags kept
              case (dir_pick)
                2'h0: begin
                  port_a_direction_q <= accum_q;
                end
                2'h1: begin
                  port_b_direction_q <= accum_q;
                end
                2'h2: begin
                  port_c_direction_q <= accum_q;
                end
                default: begin
                  port_a_direction_q <= port_a_direction_q;
                end
              endcase
            end
            `XDL_CMD_LIT_XOR: begin
              accum_q <= lit_res;
              status_q[`XDL_ST_ZERO] <= xdl_is_zero(lit_res);
            end
            `XDL_CMD_FILE_XOR: begin
              status_q[`XDL_ST_ZERO] <= xdl_is_zero(file_res);
              if (operand_q[`XDL_OP_DEST]) begin
                file_we_out    <= 1'b1;
                file_addr_out  <= operand_q[6:0];
                file_wdata_out <= file_res;
                file_data_q    <= file_res;
              end else begin
                accum_q <= file_res;
              end
            end
            default: begin
              accum_q <= accum_q;
            end
          endcase
        end
      end
    end
  end

  // read answer and waitrequest, low for one cycle per access
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out     <= 32'h0;
      avs_waitrequest_out  <= 1'b1;
    end else begin
      avs_waitrequest_out  <= !((avs_read_in || avs_write_in) && !ack_q);
      if (rd_go) begin
        avs_readdata_out <= xdl_read_mux(idx, port_a_direction_q,
          port_b_direction_q, port_c_direction_q, accum_q, status_q,
          operand_q, file_data_q);
      end
    end
  end

  // mirrored outputs, one cycle behind their registers
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_a_direction_out <= `XDL_DIR_RESET;
      port_b_direction_out <= `XDL_DIR_RESET;
      port_c_direction_out <= `XDL_DIR_RESET;
      accum_out            <= `XDL_RESET_BYTE;
      zero_flag_out        <= 1'b0;
    end else begin
      port_a_direction_out <= port_a_direction_q;
      port_b_direction_out <= port_b_direction_q;
      port_c_direction_out <= port_c_direction_q;
      accum_out            <= accum_q;
      zero_flag_out        <= status_q[`XDL_ST_ZERO];
    end
  end

endmodule // xdl_exec

// ==== xdl_exec_checker.sv ====
`timescale 1ns/1ps
module xdl_checker (
  input wire        core_clk_in,
  input wire        rst_in,
  input wire [9:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        file_we_out,
  input wire [6:0]  file_addr_out,
  input wire [7:0]  port_a_direction_out,
  input wire        zero_flag_out
);
  // every property on the core clock, off during reset
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  answer_one_a: assert property
    ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
    else $error("no answer after one cycle");
  we_pulse_a: assert property (file_we_out |=> !file_we_out)
    else $error("file write longer than one cycle");
  addr_hold_a: assert property (file_we_out |=> $stable(file_addr_out))
    else $error("file address moved after write");
  unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in == 10'h3fc |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (avs_read_in && !avs_waitrequest_out
    |-> avs_readdata_out[31:8] == 24'h0) else $error("upper bits set");
  dir_cause_a: assert property ($changed(port_a_direction_out) |->
    $past(avs_write_in) || $past(avs_write_in, 2))
    else $error("direction changed with no write");
  zero_cause_a: assert property ($changed(zero_flag_out) |->
    $past(avs_write_in) || $past(avs_write_in, 2))
    else $error("zero changed with no write");
  cv_read: cover property (avs_read_in && !avs_waitrequest_out);
  cv_fwe: cover property (file_we_out);
  cv_dir: cover property ($changed(port_a_direction_out));
endmodule // xdl_checker
bind xdl_exec xdl_checker xdl_checker_inst (.*);

// ==== test_xdl_exec.sv ====
`timescale 1ns/1ps
`include "xdl_map.vh"
module test_xdl_exec;
  localparam [9:0] AC = {`XDL_IDX_ACCUM, 2'b00};
  localparam [9:0] ST = {`XDL_IDX_STATUS, 2'b00};
  localparam [9:0] OP = {`XDL_IDX_OPERAND, 2'b00};
  localparam [9:0] CM = {`XDL_IDX_COMMAND, 2'b00};
  localparam [9:0] FD = {`XDL_IDX_FILE_DATA, 2'b00};
  localparam [9:0] DA = {`XDL_IDX_PORT_A_DIR, 2'b00};
  reg        clk = 0, rst = 1, rd = 0, wr = 0;
  reg [9:0]  ad = 0;
  reg [31:0] wd = 0, rv;
  wire [31:0] rq;
  wire        wt, fwe, zf;
  wire [6:0]  fa;
  wire [7:0]  fw, da, db, dc, acc;
  integer    errors = 0, check_count = 0, cyc = 0, fn = 0, n, i, d;
  integer    seed = 32'h42ab2bc8;
  reg [7:0]  a, k, f, q, r, cfa, cfw;
  reg [7:0]  dir [0:2];
  xdl_exec xdl_exec_inst (.core_clk_in(clk), .rst_in(rst),
    .avs_address_in(ad), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'h1), .avs_readdata_out(rq),
    .avs_waitrequest_out(wt), .file_we_out(fwe), .file_addr_out(fa),
    .file_wdata_out(fw), .port_a_direction_out(da),
    .port_b_direction_out(db), .port_c_direction_out(dc),
    .accum_out(acc), .zero_flag_out(zf));
  // clock, timeout and capture of file write-backs
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fwe === 1'b1) begin
      fn <= fn + 1;
      cfa <= {1'b0, fa};
      cfw <= fw;
    end
    if (cyc == 6000) begin
      errors = errors + 1;
      print_verdict;
    end
  end
  task chk(input [31:0] s, input [31:0] e, input [47:0] nm);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("unexpected %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task bus(input w, input [9:0] adr, input [7:0] v);
    begin
      @(posedge clk);
      ad <= adr;
      wr <= w;
      rd <= !w;
      wd <= {24'h0, v};
      @(posedge clk);
      while (wt !== 1'b0) @(posedge clk);
      rv = rq;
      wr <= 0;
      rd <= 0;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    for (d = 0; d < 3; d = d + 1) dir[d] = `XDL_DIR_RESET;
    repeat (2) @(posedge clk);
    rst <= 0;
    bus(1, ST, 8'h07);
    for (i = 0; i < 5; i = i + 1) begin // selectors 4 to 8
      a = $random(seed);
      bus(1, AC, a);
      bus(1, OP, 8'h04 + i);
      bus(1, CM, `XDL_CMD_DIR_LOAD);
      if (i > 0 && i < 4) dir[i - 1] = a;
      for (d = 0; d < 3; d = d + 1) begin
        bus(0, DA + 4 * d, 0);
        chk(rv, dir[d], "dir");
      end
      bus(0, ST, 0);
      chk(rv, 8'h07, "status");
      chk({da, db, dc}, {dir[0], dir[1], dir[2]}, "dirpin");
    end
    for (i = 0; i < 16; i = i + 1) begin // literal then file xor
      a = $random(seed);
      f = (i % 8 == 0) ? a : $random(seed);
      r = $random(seed);
      q = {i[0], (i % 8 < 2) ? {7{i[0]}} : r[6:0]};
      bus(1, AC, a);
      bus(1, FD, f);
      bus(1, OP, i < 8 ? f : q);
      n = fn;
      bus(1, CM, i < 8 ? `XDL_CMD_LIT_XOR : `XDL_CMD_FILE_XOR);
      repeat (3) @(posedge clk);
      chk(fn - n, i >= 8 && i[0], "fwe");
      chk(acc, (i >= 8 && i[0]) ? a : a ^ f, "accpin");
      chk(zf, a == f, "zpin");
      if (fn != n) chk({cfa, cfw}, {1'b0, q[6:0], a ^ f}, "fwr");
      bus(0, (i >= 8 && i[0]) ? FD : AC, 0);
      chk(rv, a ^ f, "result");
      bus(0, ST, 0);
      chk(rv, {(a == f), 2'h3}, "zero");
    end
    bus(0, 10'h3fc, 0);
    chk(rv, 0, "unmap");
    print_verdict;
  end
endmodule // test_xdl_exec
